// ### src/ctar_top.sv
// Sixteen-bit counter/timer with auto-reload, register port and interrupt.
`timescale 1ns/100ps
// What this block does
// RULE1: The count is sixteen bits held as a low byte register and a high byte register.
// RULE2: Control bit 1 selects the source that advances the count.
// RULE3: With that bit clear the count advances on the system clock divided by one or twelve per the prescale bit.
// RULE4: With that bit set each falling edge of the count pin advances the count by one.
// RULE5: The timer supplies a trigger that can start a data conversion.
// RULE6: With no baud bit set and run set, capture mode applies when the capture bit is one, else auto-reload.
// RULE7: With run set, the baud bits select baud generation for transmit, receive or both, ignoring the capture bit.
// RULE8: Run set enables and starts the timer; run clear turns it off regardless of other bits.
// RULE9: In auto-reload mode an overflow past FFFF sets the overflow flag and requests an enabled interrupt.
// RULE10: In auto-reload mode each overflow copies the reload bytes into the count.
// RULE11: In auto-reload mode with the trigger enable set, a falling edge on the trigger pin reloads the count.
// RULE12: With the trigger enable clear, the trigger pin is ignored.
// RULE13: Both pins are synchronised and edge detected so each edge acts exactly once.
module ctar_top (
    input wire logic SYS_CLK,
    input wire logic RST_N,
    input wire logic [3:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR_EN,
    input wire logic RD_EN,
    output logic [7:0] RDATA,
    input wire logic COUNT_INPUT_PIN,
    input wire logic EXTERNAL_TRIGGER_PIN,
    output logic IRQ,
    output logic CONV_START,
    output logic TX_BAUD_TICK,
    output logic RX_BAUD_TICK
);
    import ctar_pkg::*;

    // ****************************************************************
    // Reset release and pin synchronisers.
    // ****************************************************************
    logic [1:0] rst_sync_q;
    logic rst_n;
    logic [1:0] cnt_sync_q, trg_sync_q;
    logic cnt_prev_q, trg_prev_q;
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            cnt_sync_q <= 2'h3;
            trg_sync_q <= 2'h3;
            cnt_prev_q <= 1'b1;
            trg_prev_q <= 1'b1;
        end else begin
            cnt_sync_q <= {cnt_sync_q[0], COUNT_INPUT_PIN}; // [RULE13]
            trg_sync_q <= {trg_sync_q[0], EXTERNAL_TRIGGER_PIN}; // [RULE13]
            cnt_prev_q <= cnt_sync_q[1];
            trg_prev_q <= trg_sync_q[1];
        end
    end
    logic cnt_fall, trg_fall;
    assign cnt_fall = cnt_prev_q & ~cnt_sync_q[1]; // [RULE4] [RULE13]
    assign trg_fall = trg_prev_q & ~trg_sync_q[1]; // [RULE13]

    // ****************************************************************
    // Registers and mode decode.
    // ****************************************************************
    logic [7:0] timer_two_control_q, timer_two_control_d;
    logic [7:0] clock_divide_control_q, clock_divide_control_d;
    logic [7:0] count_low_byte_q, count_low_byte_d;
    logic [7:0] count_high_byte_q, count_high_byte_d;
    logic [7:0] reload_low_byte_q, reload_low_byte_d;
    logic [7:0] reload_high_byte_q, reload_high_byte_d;
    logic [1:0] status_q, status_d;
    logic [1:0] mask_q, mask_d;
    logic [3:0] pre_q, pre_d;
    logic [7:0] rdata_q, rdata_d;
    logic irq_q, irq_d, conv_q, conv_d, txb_q, txb_d, rxb_q, rxb_d;
    ctar_mode_t mode;

    function automatic ctar_mode_t decode_mode(input logic [7:0] c);
        if (!c[BIT_RUN]) begin
            return MODE_OFF; // [RULE8]
        end else if (c[BIT_TX_BAUD] && c[BIT_RX_BAUD]) begin
            return MODE_BAUD_TXRX; // [RULE7]
        end else if (c[BIT_TX_BAUD]) begin
            return MODE_BAUD_TX; // [RULE7]
        end else if (c[BIT_RX_BAUD]) begin
            return MODE_BAUD_RX; // [RULE7]
        end else if (c[BIT_CAP_RELOAD]) begin
            return MODE_CAPTURE; // [RULE6]
        end else begin
            return MODE_RELOAD; // [RULE6]
        end
    endfunction
    assign mode = decode_mode(timer_two_control_q);

    // ****************************************************************
    // Counting, reload, flags and register port.
    // ****************************************************************
    logic [15:0] count, reload, count_inc;
    logic tick, running, overflow, trig_reload, pre_wrap;
    assign count = {count_high_byte_q, count_low_byte_q}; // [RULE1]
    assign reload = {reload_high_byte_q, reload_low_byte_q};
    assign count_inc = count + 16'h0001;
    assign running = (mode != MODE_OFF); // [RULE8]
    assign pre_wrap = (pre_q == PRESCALE_DIV - 4'h1);

    always_comb begin
        pre_d = running ? (pre_wrap ? 4'h0 : pre_q + 4'h1) : 4'h0;
        if (timer_two_control_q[BIT_CLK_SRC]) begin // [RULE2]
            tick = running & cnt_fall; // [RULE4]
        end else if (clock_divide_control_q[BIT_PRESCALE]) begin
            tick = running; // [RULE3]
        end else begin
            tick = running & pre_wrap; // [RULE3]
        end
        overflow = tick && (count == COUNT_MAX);
        trig_reload = (mode == MODE_RELOAD) && timer_two_control_q[BIT_EXT_TRIG_EN] && trg_fall; // [RULE11] [RULE12]
        timer_two_control_d = timer_two_control_q;
        clock_divide_control_d = clock_divide_control_q;
        reload_low_byte_d = reload_low_byte_q;
        reload_high_byte_d = reload_high_byte_q;
        mask_d = mask_q;
        status_d = status_q;
        {count_high_byte_d, count_low_byte_d} = count;
        if (overflow && mode == MODE_RELOAD) begin
            {count_high_byte_d, count_low_byte_d} = reload; // [RULE10]
        end else if (tick) begin
            {count_high_byte_d, count_low_byte_d} = count_inc;
        end
        if (trig_reload) begin
            {count_high_byte_d, count_low_byte_d} = reload; // [RULE11]
        end
        if (WR_EN) begin
            unique case (ADDR)
                OFS_CONTROL: timer_two_control_d = WDATA;
                OFS_CLKDIV: clock_divide_control_d = WDATA;
                OFS_COUNT_LOW: count_low_byte_d = WDATA;
                OFS_COUNT_HIGH: count_high_byte_d = WDATA;
                OFS_RELOAD_LOW: reload_low_byte_d = WDATA;
                OFS_RELOAD_HIGH: reload_high_byte_d = WDATA;
                OFS_IRQ_STATUS: status_d = status_q & ~WDATA[1:0];
                OFS_IRQ_MASK: mask_d = WDATA[1:0];
                default: begin
                end
            endcase
        end
        if (overflow && mode == MODE_RELOAD) begin
            status_d[BIT_OVF] = 1'b1; // [RULE9]
        end
        if (trig_reload) begin
            status_d[BIT_TRIG] = 1'b1;
        end
        irq_d = |(status_d & mask_d); // [RULE9]
        conv_d = overflow; // [RULE5]
        txb_d = overflow && (mode == MODE_BAUD_TX || mode == MODE_BAUD_TXRX); // [RULE7]
        rxb_d = overflow && (mode == MODE_BAUD_RX || mode == MODE_BAUD_TXRX); // [RULE7]
        rdata_d = 8'h00;
        if (RD_EN) begin
            unique case (ADDR)
                OFS_CONTROL: rdata_d = timer_two_control_q;
                OFS_CLKDIV: rdata_d = clock_divide_control_q;
                OFS_COUNT_LOW: rdata_d = count_low_byte_q;
                OFS_COUNT_HIGH: rdata_d = count_high_byte_q;
                OFS_RELOAD_LOW: rdata_d = reload_low_byte_q;
                OFS_RELOAD_HIGH: rdata_d = reload_high_byte_q;
                OFS_IRQ_STATUS: rdata_d = {6'h00, status_q};
                OFS_IRQ_MASK: rdata_d = {6'h00, mask_q};
                default: rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            timer_two_control_q <= RESET_BYTE;
            clock_divide_control_q <= RESET_BYTE;
            count_low_byte_q <= RESET_BYTE;
            count_high_byte_q <= RESET_BYTE;
            reload_low_byte_q <= RESET_BYTE;
            reload_high_byte_q <= RESET_BYTE;
            status_q <= 2'h0;
            mask_q <= 2'h0;
            pre_q <= 4'h0;
            rdata_q <= 8'h00;
            irq_q <= 1'b0;
            conv_q <= 1'b0;
            txb_q <= 1'b0;
            rxb_q <= 1'b0;
        end else begin
            timer_two_control_q <= timer_two_control_d;
            clock_divide_control_q <= clock_divide_control_d;
            count_low_byte_q <= count_low_byte_d;
            count_high_byte_q <= count_high_byte_d;
            reload_low_byte_q <= reload_low_byte_d;
            reload_high_byte_q <= reload_high_byte_d;
            status_q <= status_d;
            mask_q <= mask_d;
            pre_q <= pre_d;
            rdata_q <= rdata_d;
            irq_q <= irq_d;
            conv_q <= conv_d;
            txb_q <= txb_d;
            rxb_q <= rxb_d;
        end
    end
    assign RDATA = rdata_q;
    assign IRQ = irq_q;
    assign CONV_START = conv_q;
    assign TX_BAUD_TICK = txb_q;
    assign RX_BAUD_TICK = rxb_q;

    // ****************************************************************
    // Assertions.
    // ****************************************************************
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!rst_n);

    sequence s_reload_ovf;
        mode == MODE_RELOAD && overflow && !WR_EN && !trig_reload;
    endsequence
    property p_reload_value;
        s_reload_ovf |=> count == $past(reload);
    endproperty
    a_reload_value: assert property (p_reload_value) else $error("Overflow did not reload count."); // [RULE10]
    property p_ovf_flag;
        s_reload_ovf |=> status_q[BIT_OVF];
    endproperty
    a_ovf_flag: assert property (p_ovf_flag) else $error("Overflow flag not set."); // [RULE9]
    property p_irq;
        (status_q & mask_q) != 2'h0 && !WR_EN |=> IRQ;
    endproperty
    a_irq: assert property (p_irq) else $error("Interrupt not raised."); // [RULE9]
    property p_off;
        mode == MODE_OFF && !WR_EN && !trig_reload |=> $stable(count);
    endproperty
    a_off: assert property (p_off) else $error("Stopped timer counted."); // [RULE8]
    property p_ext_count;
        running && timer_two_control_q[BIT_CLK_SRC] && !cnt_fall && !WR_EN && !trig_reload |=> $stable(count);
    endproperty
    a_ext_count: assert property (p_ext_count) else $error("Count moved without pin edge."); // [RULE4]
    property p_div1;
        running && !timer_two_control_q[BIT_CLK_SRC] && clock_divide_control_q[BIT_PRESCALE]
            && count != COUNT_MAX && !WR_EN && !trig_reload |=> count == $past(count) + 16'h0001;
    endproperty
    a_div1: assert property (p_div1) else $error("Undivided clock did not count."); // [RULE3]
    property p_div12;
        running && !timer_two_control_q[BIT_CLK_SRC] && !clock_divide_control_q[BIT_PRESCALE]
            && !pre_wrap && !WR_EN && !trig_reload |=> $stable(count);
    endproperty
    a_div12: assert property (p_div12) else $error("Divided clock counted early."); // [RULE3]
    property p_trig_ignore;
        !timer_two_control_q[BIT_EXT_TRIG_EN] && !WR_EN |=> !$rose(status_q[BIT_TRIG]);
    endproperty
    a_trig_ignore: assert property (p_trig_ignore) else $error("Trigger acted while disabled."); // [RULE12]
    property p_trig_reload;
        trig_reload && !WR_EN |=> count == $past(reload);
    endproperty
    a_trig_reload: assert property (p_trig_reload) else $error("Trigger did not reload."); // [RULE11]
    property p_edge_once;
        running && timer_two_control_q[BIT_CLK_SRC] && cnt_fall && count != COUNT_MAX
            && !WR_EN && !trig_reload |=> count == $past(count) + 16'h0001;
    endproperty
    a_edge_once: assert property (p_edge_once) else $error("Pin edge did not count once."); // [RULE4] [RULE13]

    // ****************************************************************
    // Assertions on outputs, flags, edge detection, prescaler and counting.
    // ****************************************************************
    sequence s_count_pin_fall;
        cnt_sync_q[1] ##1 !cnt_sync_q[1];
    endsequence
    sequence s_trig_pin_fall;
        trg_sync_q[1] ##1 !trg_sync_q[1];
    endsequence
    property p_fall_detect;
        s_count_pin_fall |-> cnt_fall;
    endproperty
    a_fall_detect: assert property (p_fall_detect) else $error("Count pin edge missed."); // [RULE13]
    property p_trig_fall_detect;
        s_trig_pin_fall |-> trg_fall;
    endproperty
    a_trig_fall_detect: assert property (p_trig_fall_detect) else $error("Trigger pin edge missed."); // [RULE13]
    property p_conv;
        overflow |=> CONV_START;
    endproperty
    a_conv: assert property (p_conv) else $error("Conversion start not pulsed."); // [RULE5]
    property p_tx_tick;
        overflow && (mode == MODE_BAUD_TX || mode == MODE_BAUD_TXRX) |=> TX_BAUD_TICK;
    endproperty
    a_tx_tick: assert property (p_tx_tick) else $error("Transmit baud tick missing."); // [RULE7]
    property p_rx_tick;
        overflow && (mode == MODE_BAUD_RX || mode == MODE_BAUD_TXRX) |=> RX_BAUD_TICK;
    endproperty
    a_rx_tick: assert property (p_rx_tick) else $error("Receive baud tick missing."); // [RULE7]
    property p_capture_wrap;
        mode == MODE_CAPTURE && overflow && !WR_EN |=> count == 16'h0000;
    endproperty
    a_capture_wrap: assert property (p_capture_wrap) else $error("Capture mode did not wrap to zero."); // [RULE6]
    property p_no_flag;
        mode != MODE_RELOAD && !WR_EN |=> !$rose(status_q[BIT_OVF]);
    endproperty
    a_no_flag: assert property (p_no_flag) else $error("Overflow flag set outside auto-reload."); // [RULE6]
    property p_flag_sticky;
        status_q[BIT_OVF] && !WR_EN |=> status_q[BIT_OVF];
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("Overflow flag dropped by itself."); // [RULE9]
    property p_prescale_idle;
        !running |=> pre_q == 4'h0;
    endproperty
    a_prescale_idle: assert property (p_prescale_idle) else $error("Prescaler ran while stopped."); // [RULE8]
    property p_div12_tick;
        running && !timer_two_control_q[BIT_CLK_SRC] && !clock_divide_control_q[BIT_PRESCALE] && pre_wrap
            && count != COUNT_MAX && !WR_EN && !trig_reload |=> count == $past(count) + 16'h0001;
    endproperty
    a_div12_tick: assert property (p_div12_tick) else $error("Divided clock did not count."); // [RULE3]
endmodule // ctar_top

// ### src/ctar_pkg.sv
// Package of constants for the auto-reload counter/timer.
package ctar_pkg;
    // ****************************************************************
    // Register offsets.
    // ****************************************************************
    localparam logic [3:0] OFS_CONTROL = 4'h0;
    localparam logic [3:0] OFS_CLKDIV = 4'h1;
    localparam logic [3:0] OFS_COUNT_LOW = 4'h2;
    localparam logic [3:0] OFS_COUNT_HIGH = 4'h3;
    localparam logic [3:0] OFS_RELOAD_LOW = 4'h4;
    localparam logic [3:0] OFS_RELOAD_HIGH = 4'h5;
    localparam logic [3:0] OFS_IRQ_STATUS = 4'h6;
    localparam logic [3:0] OFS_IRQ_MASK = 4'h7;
    // ****************************************************************
    // Control and clock-divide register bit positions.
    // ****************************************************************
    localparam int BIT_EXT_TRIG_EN = 3;
    localparam int BIT_RUN = 2;
    localparam int BIT_CLK_SRC = 1;
    localparam int BIT_CAP_RELOAD = 0;
    localparam int BIT_TX_BAUD = 4;
    localparam int BIT_RX_BAUD = 5;
    localparam int BIT_PRESCALE = 0;
    // ****************************************************************
    // Interrupt status bit positions.
    // ****************************************************************
    localparam int BIT_OVF = 0;
    localparam int BIT_TRIG = 1;
    // ****************************************************************
    // Reset values and timing.
    // ****************************************************************
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [15:0] COUNT_MAX = 16'hFFFF;
    localparam logic [3:0] PRESCALE_DIV = 4'hC;
    typedef enum logic [2:0] {
        MODE_OFF = 3'b000,
        MODE_CAPTURE = 3'b001,
        MODE_RELOAD = 3'b010,
        MODE_BAUD_TX = 3'b011,
        MODE_BAUD_RX = 3'b100,
        MODE_BAUD_TXRX = 3'b101
    } ctar_mode_t;
endpackage // ctar_pkg

// ### testbench/ctar_pins.sv
// Model of the far side: the external count pin and the external trigger pin.
`timescale 1ns/100ps
module ctar_pins (
    input wire logic clk,
    output logic count_pin,
    output logic trig_pin
);
    initial begin
        count_pin = 1'b1;
        trig_pin = 1'b1;
    end
    // One falling edge on the chosen pin, held low and then high for lo cycles each.
    task automatic fall(input logic trig, input int lo);
        @(posedge clk);
        trig_pin <= ~trig;
        count_pin <= trig;
        repeat (lo) @(posedge clk);
        trig_pin <= 1'b1;
        count_pin <= 1'b1;
        repeat (lo) @(posedge clk);
    endtask
endmodule // ctar_pins

// ### testbench/counter_timer_auto_reload_tb.sv
// Self-checking testbench of the auto-reload counter/timer.
`timescale 1ns/100ps
module counter_timer_auto_reload_tb;
    import ctar_pkg::*;
    logic clk, rst_n, wr_en, rd_en, cnt_pin, trg_pin, irq, conv, txt, rxt;
    logic [3:0] addr;
    logic [7:0] wdata, rdata;
    logic [15:0] rv, v, e;
    int error_cnt = 0, cmp_count = 0, n_conv = 0, n_tx = 0, n_rx = 0, c0, t0, r0;
    logic [7:0] ctl [6] = '{8'h02, 8'h06, 8'h07, 8'h16, 8'h26, 8'h36};
    ctar_top u_dut (.SYS_CLK(clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR_EN(wr_en),
        .RD_EN(rd_en), .RDATA(rdata), .COUNT_INPUT_PIN(cnt_pin), .EXTERNAL_TRIGGER_PIN(trg_pin),
        .IRQ(irq), .CONV_START(conv), .TX_BAUD_TICK(txt), .RX_BAUD_TICK(rxt));
    ctar_pins u_pins (.clk(clk), .count_pin(cnt_pin), .trig_pin(trg_pin));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        n_conv <= n_conv + int'(conv);
        n_tx <= n_tx + int'(txt);
        n_rx <= n_rx + int'(rxt);
    end
    // Count expected after three count edges from FFFE in a given control setting.
    function automatic logic [15:0] after_wrap(input logic [7:0] c, input logic [15:0] r);
        if (!c[2]) return 16'hFFFE;
        return (c[5:4] == 2'b00 && !c[0]) ? r + 16'h0001 : 16'h0001;
    endfunction
    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        d = rdata;
    endtask
    task automatic wr16(input logic [3:0] a, input logic [15:0] d);
        wr(a, d[7:0]);
        wr(a + 4'h1, d[15:8]);
    endtask
    task automatic rd16(input logic [3:0] a, output logic [15:0] d);
        rd(a, d[7:0]);
        rd(a + 4'h1, d[15:8]);
    endtask
    task automatic settle();
        repeat (2) @(posedge clk);
        #1;
    endtask
    initial begin
        #500000;
        error_cnt++;
        wrap_up();
    end
    initial begin
        rst_n = 1'b0;
        wr_en = 1'b0;
        rd_en = 1'b0;
        addr = 4'h0;
        wdata = 8'h00;
        void'($urandom(32'hC1011967));
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        for (int a = 0; a < 9; a++) begin
            rd(a[3:0], v[7:0]);
            chk("reset_value", {8'h00, v[7:0]}, 16'h0000);
        end
        rv = 16'($urandom);
        wr16(OFS_COUNT_LOW, rv);
        repeat (20) @(posedge clk);
        rd16(OFS_COUNT_LOW, v);
        chk("count_bytes", v, rv);
        for (int p = 1; p >= 0; p--) begin
            wr(OFS_CLKDIV, 8'(p));
            wr16(OFS_COUNT_LOW, 16'h0000);
            wr(OFS_CONTROL, 8'h04);
            repeat (240) @(posedge clk);
            wr(OFS_CONTROL, 8'h00);
            rd16(OFS_COUNT_LOW, v);
            e = (p == 1) ? 16'd241 : 16'd20;
            chk("clock_rate", {15'h0000, v + 16'd3 > e && v < e + 16'd4}, 16'h0001);
        end
        wr(OFS_CLKDIV, 8'h01);
        wr(OFS_IRQ_MASK, 8'h01);
        wr16(OFS_RELOAD_LOW, 16'h8000);
        wr16(OFS_COUNT_LOW, 16'hFFF0);
        wr(OFS_CONTROL, 8'h04);
        for (int i = 0; i < 100 && irq !== 1'b1; i++) @(posedge clk);
        chk("irq_raised", {15'h0000, irq}, 16'h0001);
        if (irq !== 1'b1) wrap_up();
        wr(OFS_CONTROL, 8'h00);
        rd(OFS_IRQ_STATUS, v[7:0]);
        chk("ovf_flag", {8'h00, v[7:0]}, 16'h0001);
        wr(OFS_IRQ_MASK, 8'h00);
        settle();
        chk("irq_masked", {15'h0000, irq}, 16'h0000);
        wr(OFS_IRQ_MASK, 8'h01);
        settle();
        chk("irq_unmasked", {15'h0000, irq}, 16'h0001);
        wr(OFS_IRQ_STATUS, 8'h01);
        settle();
        chk("irq_cleared", {15'h0000, irq}, 16'h0000);
        foreach (ctl[i]) begin
            rv = 16'($urandom_range(32'h0000FFFE));
            wr16(OFS_RELOAD_LOW, rv);
            wr16(OFS_COUNT_LOW, 16'hFFFE);
            wr(OFS_IRQ_STATUS, 8'h03);
            wr(OFS_CONTROL, ctl[i]);
            c0 = n_conv;
            t0 = n_tx;
            r0 = n_rx;
            repeat (3) u_pins.fall(1'b0, 2 + i);
            repeat (8) @(posedge clk);
            rd16(OFS_COUNT_LOW, v);
            chk("mode_count", v, after_wrap(ctl[i], rv));
            chk("conv_start", 16'(n_conv - c0), {15'h0000, ctl[i][2]});
            chk("tx_tick", 16'(n_tx - t0), {15'h0000, ctl[i][4]});
            chk("rx_tick", 16'(n_rx - r0), {15'h0000, ctl[i][5]});
            rd(OFS_IRQ_STATUS, v[7:0]);
            if (ctl[i][5:0] == 6'h02 || ctl[i][5:0] == 6'h06) begin
                chk("mode_flag", {15'h0000, v[0]}, {15'h0000, ctl[i][2]});
            end
        end
        rv = 16'($urandom);
        wr16(OFS_RELOAD_LOW, rv);
        for (int en = 0; en < 2; en++) begin
            wr16(OFS_COUNT_LOW, 16'h1234);
            wr(OFS_IRQ_STATUS, 8'h03);
            wr(OFS_CONTROL, (en == 1) ? 8'h0E : 8'h06);
            u_pins.fall(1'b1, 2);
            repeat (8) @(posedge clk);
            rd16(OFS_COUNT_LOW, v);
            chk("trig_count", v, (en == 1) ? rv : 16'h1234);
            rd(OFS_IRQ_STATUS, v[7:0]);
            chk("trig_flag", {15'h0000, v[1]}, 16'(en));
        end
        wrap_up();
    end
endmodule // counter_timer_auto_reload_tb
